// File: rtl/rlct_pkg.sv
// rlct_pkg: constants of the read latency query record and the read link
// assumes: shared by both ends of the read link and by the link assertions
package rlct_pkg;

   // ==================================================================
   // query record layout
   localparam int unsigned TBL_LEN = 88;
   localparam logic [7:0]  Q_ID       = 8'h90;
   localparam logic [7:0]  Q_LEN      = 8'h56;
   localparam logic [6:0]  OFS_ID     = 7'h00;
   localparam logic [6:0]  OFS_LEN    = 7'h01;
   localparam logic [6:0]  OFS_HDR    = 7'h04;
   localparam logic [6:0]  OFS_OPC    = 7'h06;
   localparam logic [6:0]  OFS_ROW11  = 7'h12;
   localparam logic [6:0]  OFS_ROW00  = 7'h20;
   localparam logic [6:0]  OFS_ROW01  = 7'h2e;
   localparam logic [6:0]  OFS_MODE   = 7'h02;
   localparam logic [7:0]  NOT_SUPP   = 8'hff;

   // read latency table contents, one byte per offset
   localparam logic [7:0] READ_LATENCY_TABLE [0:TBL_LEN-1] = '{
      8'h90, 8'h56, 8'h06, 8'h0e, 8'h46, 8'h43, 8'h03, 8'h13,
      8'h0b, 8'h0c, 8'hff, 8'hff, 8'h6b, 8'h6c, 8'hff, 8'hff,
      8'heb, 8'hec, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h02, 8'h01,
      8'h50, 8'h00, 8'hff, 8'hff, 8'h00, 8'h08, 8'hff, 8'hff,
      8'h00, 8'h08, 8'hff, 8'hff, 8'h02, 8'h04, 8'h5a, 8'h01,
      8'hff, 8'hff, 8'h00, 8'h08, 8'hff, 8'hff, 8'h00, 8'h08,
      8'hff, 8'hff, 8'h02, 8'h04, 8'h68, 8'h02, 8'hff, 8'hff,
      8'h00, 8'h08, 8'hff, 8'hff, 8'h00, 8'h08, 8'hff, 8'hff,
      8'h02, 8'h05, 8'h85, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

   // ==================================================================
   // read commands and latency codes
   typedef enum logic [2:0] {
      RK_NORMAL = 3'h0, RK_FAST = 3'h1, RK_DUAL_OUT = 3'h2,
      RK_QUAD_OUT = 3'h3, RK_DUAL_IO = 3'h4, RK_QUAD_IO = 3'h5
   } rlct_kind_t;

   localparam logic [7:0] OP_READ3  = 8'h03;
   localparam logic [7:0] OP_READ4  = 8'h13;
   localparam logic [7:0] OP_FAST3  = 8'h0b;
   localparam logic [7:0] OP_FAST4  = 8'h0c;
   localparam logic [7:0] OP_QOUT3  = 8'h6b;
   localparam logic [7:0] OP_QOUT4  = 8'h6c;
   localparam logic [7:0] OP_QIO3   = 8'heb;
   localparam logic [7:0] OP_QIO4   = 8'hec;

   localparam logic [1:0] LC_50MHZ  = 2'h3;
   localparam logic [1:0] LC_80MHZ  = 2'h0;
   localparam logic [1:0] LC_90MHZ  = 2'h1;

   // offset of the row for a latency code; bit 7 set when no row
   function automatic logic [7:0] rlct_row_base(input logic [1:0] code);
      unique case (code)
         LC_50MHZ: rlct_row_base = {1'b0, OFS_ROW11};
         LC_80MHZ: rlct_row_base = {1'b0, OFS_ROW00};
         LC_90MHZ: rlct_row_base = {1'b0, OFS_ROW01};
         default:  rlct_row_base = 8'h80;
      endcase
   endfunction : rlct_row_base

   // query byte at an offset; past the record reads as not supported
   function automatic logic [7:0] rlct_byte(input logic [6:0] ofs);
      if (int'(ofs) < TBL_LEN) rlct_byte = READ_LATENCY_TABLE[ofs];
      else rlct_byte = NOT_SUPP;
   endfunction : rlct_byte

endpackage : rlct_pkg

// File: rtl/rlct_link_if.sv
// rlct_link_if: wires between the read latency host and the flash end
// assumes: both ends run on the same clk_sys
`timescale 1ns/1ps
`default_nettype none
interface rlct_link_if;
   // query record read
   logic       q_req;
   logic [6:0] q_addr;
   logic       q_ack;
   logic [7:0] q_data;
   // read command
   logic       cmd_valid;
   logic [7:0] cmd_op;
   logic [1:0] cmd_lat;
   logic       cmd_ack;
   logic       cmd_nak;
   // latency phases and data
   logic       cyc_mode;
   logic       cyc_dummy;
   logic       rd_valid;
   logic [7:0] rd_data;

   modport dev  (input q_req, q_addr, cmd_valid, cmd_op, cmd_lat, cyc_mode, cyc_dummy,
                 output q_ack, q_data, cmd_ack, cmd_nak, rd_valid, rd_data);
   modport host (output q_req, q_addr, cmd_valid, cmd_op, cmd_lat, cyc_mode, cyc_dummy,
                 input q_ack, q_data, cmd_ack, cmd_nak, rd_valid, rd_data);
endinterface : rlct_link_if
`default_nettype wire

// File: rtl/rlct_flash_end.sv
// rlct_flash_end: flash side of the read link, serving the latency record
//   and checking the mode and dummy phases of each read
// assumes: host end on the same clk_sys, joined through rlct_link_if
`timescale 1ns/1ps
`default_nettype none
module rlct_flash_end
   import rlct_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   // configuration and read data source
   input  wire logic [1:0] cfg_lat_code,
   input  wire logic [7:0] mem_byte,
   // status
   output var  logic       busy,
   output var  logic       phase_err,
   output var  logic       read_done,
   // link
   rlct_link_if.dev        link
);

   // ==================================================================
   // state
   // phases run in gray order idle, mode, dummy, data
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_MODE  = 2'b01,
      ST_DUMMY = 2'b11,
      ST_DATA  = 2'b10
   } rlct_dstate_t;

   rlct_dstate_t state;
   rlct_kind_t   kind;
   logic         kind_ok;
   logic [7:0]   row;
   logic [6:0]   fld;
   logic [7:0]   mode_need;
   logic [7:0]   dummy_need;
   logic         cmd_good;
   logic [7:0]   cnt;
   logic [7:0]   dummy_cnt;
   logic         run;

   // ==================================================================
   // command decode
   // opcode to read kind; dual opcodes are FFh and never decode
   always_comb begin
      kind_ok = 1'b1;
      unique case (link.cmd_op)
         OP_READ3, OP_READ4: kind = RK_NORMAL;
         OP_FAST3, OP_FAST4: kind = RK_FAST;
         OP_QOUT3, OP_QOUT4: kind = RK_QUAD_OUT;
         OP_QIO3,  OP_QIO4:  kind = RK_QUAD_IO;
         default: begin
            kind    = RK_DUAL_OUT;
            kind_ok = 1'b0;
         end
      endcase
   end

   // cycle counts from the row of the requested latency code
   // an FFh in either count marks the command unavailable at this code,
   // so a known opcode can still be refused; a code with no row is too
   always_comb begin
      row        = rlct_row_base(link.cmd_lat);
      fld        = row[6:0] + OFS_MODE + {3'h0, kind, 1'b0};
      mode_need  = rlct_byte(fld);
      dummy_need = rlct_byte(fld + 7'h01);
      cmd_good   = kind_ok && !row[7] && link.cmd_lat == cfg_lat_code
                   && mode_need != NOT_SUPP && dummy_need != NOT_SUPP;
   end

   // ==================================================================
   // query record port: answers one cycle after each request
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         link.q_ack  <= 1'b0;
         link.q_data <= 8'h00;
      end else begin
         link.q_ack <= link.q_req;
         if (link.q_req) begin
            link.q_data <= rlct_byte(link.q_addr);
         end
      end
   end

   // ==================================================================
   // read command sequencing
   // the first strobe of a read may lag the acknowledge; once strobes
   // start they must run without a gap, so short phases are caught
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state     <= ST_IDLE;
         cnt       <= 8'h00;
         dummy_cnt <= 8'h00;
         run       <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               run <= 1'b0;
               if (link.cmd_valid && cmd_good) begin
                  cnt       <= mode_need;
                  dummy_cnt <= dummy_need;
                  if (mode_need != 8'h00) begin
                     state <= ST_MODE;
                  end else if (dummy_need != 8'h00) begin
                     state <= ST_DUMMY;
                     cnt   <= dummy_need;
                  end else begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_MODE: begin
               if (link.cyc_dummy || (run && !link.cyc_mode)) begin
                  state <= ST_IDLE;
               end else if (link.cyc_mode) begin
                  run <= 1'b1;
                  cnt <= cnt - 8'h01;
                  if (cnt == 8'h01) begin
                     cnt   <= dummy_cnt;
                     state <= (dummy_cnt == 8'h00) ? ST_DATA : ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               if (link.cyc_mode || (run && !link.cyc_dummy)) begin
                  state <= ST_IDLE;
               end else if (link.cyc_dummy) begin
                  run <= 1'b1;
                  cnt <= cnt - 8'h01;
                  if (cnt == 8'h01) begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // phase error: a strobe of the wrong phase or a gap in a phase
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         phase_err <= 1'b0;
      end else begin
         phase_err <= (state == ST_MODE && (link.cyc_dummy || (run && !link.cyc_mode)))
                      || (state == ST_DUMMY && (link.cyc_mode || (run && !link.cyc_dummy)))
                      || (state == ST_IDLE && (link.cyc_mode || link.cyc_dummy));
      end
   end

   // command answer: accept or refuse one cycle after the command
   // a command while a read is in progress is refused, not queued
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         link.cmd_ack <= 1'b0;
         link.cmd_nak <= 1'b0;
      end else begin
         link.cmd_ack <= link.cmd_valid && state == ST_IDLE && cmd_good;
         link.cmd_nak <= link.cmd_valid && !(state == ST_IDLE && cmd_good);
      end
   end

   // read data: one byte once the latency phases are complete
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         link.rd_valid <= 1'b0;
         link.rd_data  <= 8'h00;
         read_done     <= 1'b0;
      end else begin
         link.rd_valid <= state == ST_DATA;
         read_done     <= state == ST_DATA;
         if (state == ST_DATA) begin
            link.rd_data <= mem_byte;
         end
      end
   end

   // busy while a read is in progress
   // a command being taken already counts, so busy rises with the ack
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
      end else begin
         busy <= (state != ST_IDLE) || (link.cmd_valid && cmd_good);
      end
   end

endmodule : rlct_flash_end
`default_nettype wire

// File: rtl/rlct_host_end.sv
// rlct_host_end: host side of the read link; reads the latency record,
//   issues the read and inserts the tabulated mode and dummy cycles
// assumes: flash end on the same clk_sys, joined through rlct_link_if
`timescale 1ns/1ps
`default_nettype none
module rlct_host_end
   import rlct_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   // user request
   input  wire logic       start,
   input  wire logic [2:0] read_kind,
   input  wire logic       addr4,
   input  wire logic [1:0] lat_code,
   // user answer
   output var  logic       busy,
   output var  logic       done,
   output var  logic       refused,
   output var  logic [7:0] data,
   // link
   rlct_link_if.host       link
);

   // ==================================================================
   // state
   typedef enum logic [2:0] {
      HS_IDLE  = 3'b000,
      HS_QRY   = 3'b001,
      HS_CMD   = 3'b011,
      HS_MODE  = 3'b010,
      HS_DUMMY = 3'b110,
      HS_WAIT  = 3'b111
   } rlct_hstate_t;

   rlct_hstate_t state;
   logic [1:0]   step;
   logic [6:0]   fld;
   logic [7:0]   opcode;
   logic [7:0]   mode_cnt;
   logic [7:0]   dummy_cnt;
   logic [1:0]   lat;
   logic [7:0]   row_base;

   // row of the requested code; bit 7 marks a code with no row
   assign row_base = rlct_row_base(lat_code);

   // ==================================================================
   // query sequence: opcode, then mode count, then dummy count
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state          <= HS_IDLE;
         step           <= 2'h0;
         fld            <= 7'h00;
         opcode         <= 8'h00;
         mode_cnt       <= 8'h00;
         dummy_cnt      <= 8'h00;
         lat            <= 2'h0;
         link.q_req     <= 1'b0;
         link.q_addr    <= 7'h00;
         link.cmd_valid <= 1'b0;
         link.cmd_op    <= 8'h00;
         link.cmd_lat   <= 2'h0;
         link.cyc_mode  <= 1'b0;
         link.cyc_dummy <= 1'b0;
         busy           <= 1'b0;
         done           <= 1'b0;
         refused        <= 1'b0;
         data           <= 8'h00;
      end else begin
         link.q_req     <= 1'b0;
         link.cmd_valid <= 1'b0;
         done           <= 1'b0;
         refused        <= 1'b0;
         unique case (state)
            HS_IDLE: begin
               if (start) begin
                  busy <= 1'b1;
                  lat  <= lat_code;
                  step <= 2'h0;
                  fld  <= row_base[6:0] + OFS_MODE + {3'h0, read_kind, 1'b0};
                  if (row_base[7]) begin
                     busy    <= 1'b0;
                     refused <= 1'b1;
                  end else begin
                     link.q_req  <= 1'b1;
                     link.q_addr <= OFS_OPC + {3'h0, read_kind, addr4};
                     state       <= HS_QRY;
                  end
               end
            end
            HS_QRY: begin
               if (link.q_ack) begin
                  step <= step + 2'h1;
                  if (link.q_data == NOT_SUPP) begin
                     busy    <= 1'b0;
                     refused <= 1'b1;
                     state   <= HS_IDLE;
                  end else if (step == 2'h0) begin
                     opcode      <= link.q_data;
                     link.q_req  <= 1'b1;
                     link.q_addr <= fld;
                  end else if (step == 2'h1) begin
                     mode_cnt    <= link.q_data;
                     link.q_req  <= 1'b1;
                     link.q_addr <= fld + 7'h01;
                  end else begin
                     dummy_cnt      <= link.q_data;
                     link.cmd_valid <= 1'b1;
                     link.cmd_op    <= opcode;
                     link.cmd_lat   <= lat;
                     state          <= HS_CMD;
                  end
               end
            end
            HS_CMD: begin
               if (link.cmd_nak) begin
                  busy    <= 1'b0;
                  refused <= 1'b1;
                  state   <= HS_IDLE;
               end else if (link.cmd_ack) begin
                  if (mode_cnt != 8'h00) begin
                     link.cyc_mode <= 1'b1;
                     state         <= HS_MODE;
                  end else if (dummy_cnt != 8'h00) begin
                     link.cyc_dummy <= 1'b1;
                     state          <= HS_DUMMY;
                  end else begin
                     state <= HS_WAIT;
                  end
               end
            end
            HS_MODE: begin
               mode_cnt <= mode_cnt - 8'h01;
               if (mode_cnt == 8'h01) begin
                  link.cyc_mode  <= 1'b0;
                  link.cyc_dummy <= dummy_cnt != 8'h00;
                  state          <= (dummy_cnt != 8'h00) ? HS_DUMMY : HS_WAIT;
               end
            end
            HS_DUMMY: begin
               dummy_cnt <= dummy_cnt - 8'h01;
               if (dummy_cnt == 8'h01) begin
                  link.cyc_dummy <= 1'b0;
                  state          <= HS_WAIT;
               end
            end
            HS_WAIT: begin
               if (link.rd_valid) begin
                  data  <= link.rd_data;
                  done  <= 1'b1;
                  busy  <= 1'b0;
                  state <= HS_IDLE;
               end
            end
            default: state <= HS_IDLE;
         endcase
      end
   end

endmodule : rlct_host_end
`default_nettype wire

// File: bench/rlct_link_assertions.sv
// rlct_link_assertions: timing checks on the read link between the two ends
// assumes: instantiated beside the link interface, one clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module rlct_link_assertions
   import rlct_pkg::*;
(
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       resetn,
   // query port
   input wire logic       q_req,
   input wire logic       q_ack,
   input wire logic [7:0] q_data,
   // command and phases
   input wire logic       cmd_valid,
   input wire logic [7:0] cmd_op,
   input wire logic [1:0] cmd_lat,
   input wire logic       cmd_ack,
   input wire logic       cmd_nak,
   input wire logic       cyc_mode,
   input wire logic       cyc_dummy,
   input wire logic       rd_valid
);
   // ==================================================================
   // helper state
   logic [7:0] op_q;
   logic [1:0] lat_q;
   logic       qio;

   // remember the last command issued, taken or not; phases are judged against it
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         op_q  <= 8'h00;
         lat_q <= 2'h0;
      end else if (cmd_valid) begin
         op_q  <= cmd_op;
         lat_q <= cmd_lat;
      end
   end
   assign qio = (op_q == OP_QIO3) || (op_q == OP_QIO4);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // ==================================================================
   // assertions
   a_query_answer: assert property (q_req |=> q_ack)
      else $error("query request not answered next cycle");
   a_ack_has_cause: assert property (q_ack |-> $past(q_req))
      else $error("query answer without request");
   a_cmd_answered: assert property (cmd_valid |=> (cmd_ack != cmd_nak))
      else $error("command not answered by exactly one of ack or nak");
   a_opcode_legal: assert property (
      cmd_valid |-> cmd_op inside {8'h03, 8'h13, 8'h0b, 8'h0c, 8'h6b, 8'h6c, 8'heb, 8'hec})
      else $error("unsupported read opcode issued");
   a_quick_no_wait: assert property (
      cmd_ack && lat_q == 2'h3 && !qio |=> rd_valid && !(cyc_mode || cyc_dummy))
      else $error("latency at the slowest clock row");
   a_qio_quick: assert property (
      $rose(cyc_mode) && qio && lat_q == 2'h3 |-> cyc_mode ##1 cyc_mode ##1 (cyc_dummy && !cyc_mode) ##1 !cyc_dummy)
      else $error("quad io phases wrong at code 11b");
   a_qio_slow: assert property (
      $rose(cyc_mode) && lat_q != 2'h3 |-> cyc_mode[*2] ##1 (cyc_dummy && !cyc_mode)[*4] ##1 !cyc_dummy)
      else $error("quad io phases wrong at faster rows");
   a_eight_dummy: assert property (
      $rose(cyc_dummy) && !$past(cyc_mode) && lat_q != 2'h3 |-> cyc_dummy[*8] ##1 !cyc_dummy)
      else $error("dummy run not eight cycles");
   a_data_follows: assert property ($fell(cyc_dummy) |-> !rd_valid ##1 rd_valid)
      else $error("read data not two cycles after last dummy");

   // ==================================================================
   // covers
   c_data: cover property (rd_valid);
   c_mode: cover property ($rose(cyc_mode));
   c_unsupp: cover property (q_ack && q_data == NOT_SUPP);
endmodule : rlct_link_assertions
`default_nettype wire

// File: bench/read_latency_code_table_test.sv
// read_latency_code_table_test: host and flash ends joined, every kind and code
// read; a second flash end driven directly to break the link order on purpose
// assumes: rlct_pkg, rlct_link_if and both ends compiled before it
`timescale 1ns/1ps
`default_nettype none
module read_latency_code_table_test;
   // ==================================================================
   // stimulus and observation
   logic       clk_sys   = 1'b0;
   logic       resetn    = 1'b0;
   logic       start     = 1'b0;
   logic [2:0] read_kind = 3'h0;
   logic       addr4     = 1'b0;
   logic [1:0] lat_code  = 2'h3;
   logic [7:0] mem_byte  = 8'h00;
   logic [1:0] cfg_b     = 2'h3;
   logic       done, refused, err_b;
   logic       busy_h, busy_f, busy_b, rdone, perr;
   logic [7:0] data;
   logic [7:0] seen_op   = 8'h00;
   int         failures  = 0;
   int         checks    = 0;
   int         n_mode    = 0;
   int         n_dummy   = 0;
   int         n_cmd     = 0;
   int         n_err     = 0;
   int         n_rdone   = 0;
   int         n_perr    = 0;
   localparam logic [6:0] QA [11] = '{7'h00, 7'h01, 7'h04, 7'h05, 7'h0a, 7'h13, 7'h1e, 7'h1f, 7'h21, 7'h22, 7'h58};
   localparam logic [7:0] QD [11] = '{8'h90, 8'h56, 8'h46, 8'h43, 8'hff, 8'h03, 8'h02, 8'h01, 8'h00, 8'hff, 8'hff};

   rlct_link_if link ();
   rlct_link_if link_b ();

   rlct_host_end rlct_host_end_inst (.clk_sys(clk_sys), .resetn(resetn), .start(start), .read_kind(read_kind),
      .addr4(addr4), .lat_code(lat_code), .busy(busy_h), .done(done), .refused(refused), .data(data), .link(link));
   rlct_flash_end rlct_flash_end_inst (.clk_sys(clk_sys), .resetn(resetn), .cfg_lat_code(lat_code),
      .mem_byte(mem_byte), .busy(busy_f), .phase_err(perr), .read_done(rdone), .link(link));
   rlct_flash_end rlct_flash_end_inst_b (.clk_sys(clk_sys), .resetn(resetn), .cfg_lat_code(cfg_b),
      .mem_byte(8'h5a), .busy(busy_b), .phase_err(err_b), .read_done(), .link(link_b));
   rlct_link_assertions rlct_link_assertions_inst (.clk_sys(clk_sys), .resetn(resetn), .q_req(link.q_req),
      .q_ack(link.q_ack), .q_data(link.q_data), .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op),
      .cmd_lat(link.cmd_lat), .cmd_ack(link.cmd_ack), .cmd_nak(link.cmd_nak), .cyc_mode(link.cyc_mode),
      .cyc_dummy(link.cyc_dummy), .rd_valid(link.rd_valid));

   // clock, 4 ns period
   initial forever #2 clk_sys = ~clk_sys;

   // count strobes, commands and flags on the joined link, faults on the second
   always @(posedge clk_sys) begin
      n_mode  <= n_mode + int'(link.cyc_mode);
      n_dummy <= n_dummy + int'(link.cyc_dummy);
      if (link.cmd_valid) begin
         n_cmd   <= n_cmd + 1;
         seen_op <= link.cmd_op;
      end
      n_err   <= n_err + int'(err_b);
      n_rdone <= n_rdone + int'(rdone);
      n_perr  <= n_perr + int'(perr);
   end

   // ==================================================================
   // tasks
   task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk8

   task automatic wrap_up();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   // one read through the host end, expectations from the latency rows
   task automatic do_read(input logic [2:0] k, input logic a4, input logic [1:0] c);
      int         m0, d0, c0, r0, p0;
      logic       ok;
      logic [7:0] op, m, d;
      ok = (c != 2'h2) && (k != 3'h2) && (k != 3'h4) && !(k == 3'h0 && c != 2'h3);
      case (k)
         3'h0:    op = a4 ? 8'h13 : 8'h03;
         3'h1:    op = a4 ? 8'h0c : 8'h0b;
         3'h3:    op = a4 ? 8'h6c : 8'h6b;
         default: op = a4 ? 8'hec : 8'heb;
      endcase
      m = (k == 3'h5) ? 8'h02 : 8'h00;
      d = (c == 2'h3) ? ((k == 3'h5) ? 8'h01 : 8'h00) : ((k == 3'h5) ? 8'h04 : 8'h08);
      @(posedge clk_sys);
      m0 = n_mode;
      d0 = n_dummy;
      c0 = n_cmd;
      r0 = n_rdone;
      p0 = n_perr;
      start     <= 1'b1;
      read_kind <= k;
      addr4     <= a4;
      lat_code  <= c;
      mem_byte  <= {k, a4, c, 2'h1};
      @(posedge clk_sys);
      start <= 1'b0;
      for (int i = 0; i < 100 && done !== 1'b1 && refused !== 1'b1; i++) @(posedge clk_sys);
      chk8({7'h0, ok}, {7'h0, done});
      chk8({7'h0, !ok}, {7'h0, refused});
      chk8({7'h0, ok}, 8'(n_rdone - r0));
      chk8(8'h00, 8'(n_perr - p0));
      chk8(8'h00, {6'h0, busy_h, busy_f});
      if (ok) begin
         chk8(op, seen_op);
         chk8(m, 8'(n_mode - m0));
         chk8(d, 8'(n_dummy - d0));
         chk8({k, a4, c, 2'h1}, data);
      end else begin
         chk8(8'h00, 8'(n_cmd - c0));
      end
   endtask : do_read

   // query one byte of the record on the second link
   task automatic q_read(input logic [6:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      link_b.q_req  <= 1'b1;
      link_b.q_addr <= a;
      @(posedge clk_sys);
      link_b.q_req <= 1'b0;
      #1 chk8(8'h01, {7'h0, link_b.q_ack});
      chk8(exp, link_b.q_data);
   endtask : q_read

   // one command on the second link; exp is {ack, nak}
   task automatic cmd_b(input logic [7:0] op, input logic [1:0] lat, input logic [1:0] exp);
      @(posedge clk_sys);
      link_b.cmd_valid <= 1'b1;
      link_b.cmd_op    <= op;
      link_b.cmd_lat   <= lat;
      @(posedge clk_sys);
      link_b.cmd_valid <= 1'b0;
      #1 chk8({6'h0, exp}, {6'h0, link_b.cmd_ack, link_b.cmd_nak});
      chk8({7'h0, exp[1]}, {7'h0, busy_b});
   endtask : cmd_b

   // two cycles of {mode, dummy} strobes out of order, then a fault is due
   task automatic strobe_b(input logic [3:0] s);
      int e0;
      @(posedge clk_sys);
      e0 = n_err;
      link_b.cyc_mode  <= s[3];
      link_b.cyc_dummy <= s[2];
      @(posedge clk_sys);
      link_b.cyc_mode  <= s[1];
      link_b.cyc_dummy <= s[0];
      @(posedge clk_sys);
      link_b.cyc_mode  <= 1'b0;
      link_b.cyc_dummy <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk8(8'h01, 8'(n_err - e0));
   endtask : strobe_b

   // ==================================================================
   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      wrap_up();
   end

   // main sequence
   initial begin
      link_b.q_req     = 1'b0;
      link_b.q_addr    = 7'h00;
      link_b.cmd_valid = 1'b0;
      link_b.cmd_op    = 8'h00;
      link_b.cmd_lat   = 2'h0;
      link_b.cyc_mode  = 1'b0;
      link_b.cyc_dummy = 1'b0;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 6; k++) begin
            for (int a = 0; a < 2; a++) do_read(3'(k), 1'(a), 2'(c));
         end
      end
      for (int i = 0; i < 11; i++) q_read(QA[i], QD[i]);
      strobe_b(4'b1000);
      cmd_b(8'heb, 2'h3, 2'b10);
      strobe_b(4'b1001);
      cfg_b <= 2'h0;
      cmd_b(8'h13, 2'h0, 2'b01);
      cmd_b(8'h0b, 2'h3, 2'b01);
      cmd_b(8'h0b, 2'h0, 2'b10);
      strobe_b(4'b0100);
      wrap_up();
   end
endmodule : read_latency_code_table_test
`default_nettype wire
